//--- logic/cscr_alu.sv
// Combinational 8-bit ALU with flag generation for the core register block.
// Assumes operands and old flags come from registers in the same clock domain.
module cscr_alu
(
    input wire logic [3:0] op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [7:0] flags_in,
    output cscr_pkg::cscr_alu_out_type result
);
    import cscr_pkg::*;

    logic [7:0] bx;
    logic cin;
    logic arith;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] sum7;
    logic wrap;

    always_comb
    begin
        bx = b;
        cin = 1'b0;
        arith = 1'b1;
        case (op)
            CMD_ADC: cin = flags_in[FLG_ARITH_OUT];
            CMD_SUB:
            begin
                bx = ~b;
                cin = 1'b1;
            end
            CMD_SBC:
            begin
                bx = ~b;
                cin = flags_in[FLG_ARITH_OUT];
            end
            CMD_ADD: arith = 1'b1;
            default: arith = 1'b0;
        endcase
        sum = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
        low_sum = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        sum7 = {1'b0, a[6:0]} + {1'b0, bx[6:0]} + {7'h00, cin};
        // Carry into the top bit against carry out of it
        wrap = sum7[7] ^ sum[8];
        result.flags = flags_in;
        result.res = sum[7:0];
        if (arith)
        begin
            result.flags[FLG_ARITH_OUT] = sum[8];
            result.flags[FLG_HALF_NIBBLE] = low_sum[4];
            result.flags[FLG_SIGNED_WRAP] = wrap;
            result.flags[FLG_SIGN_RESULT] = wrap ^ sum[7];
        end
        case (op)
            CMD_AND: result.res = a & b;
            CMD_OR: result.res = a | b;
            CMD_XOR: result.res = a ^ b;
            CMD_RLC: result.res = {b[6:0], flags_in[FLG_ARITH_OUT]};
            CMD_RRC: result.res = {flags_in[FLG_ARITH_OUT], b[7:1]};
            CMD_INC: result.res = b + 8'h01;
            CMD_DEC: result.res = b - 8'h01;
            default: result.res = sum[7:0];
        endcase
        if (op == CMD_RLC)
        begin
            result.flags[FLG_ARITH_OUT] = b[7];
        end
        else if (op == CMD_RRC)
        begin
            result.flags[FLG_ARITH_OUT] = b[0];
        end
        else
        begin
            result.flags[FLG_RESULT_NULL] = (result.res == 8'h00);
        end
        // Only subtract forms define the combined null flag
        if (op == CMD_SUB)
        begin
            result.flags[FLG_COMBINED_NULL] = (result.res == 8'h00);
        end
        else if (op == CMD_SBC)
        begin
            result.flags[FLG_COMBINED_NULL] = (result.res == 8'h00) &
                flags_in[FLG_RESULT_NULL];
        end
    end

endmodule : cscr_alu

//--- logic/cscr_core_regs.sv
// Core special registers of an 8-bit CPU: working register, program counter low
// byte, lookup pointers and result, flag register; all reached over APB.
// Assumes program memory answers one cycle after pmem_req and a watchdog and
// sleep controller on pclk that use dog_timeout, dog_kick and sleep_req.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.

//Contract
//- ALU results always land in working register
//- Writing program counter low jumps within page
//- One dummy cycle after program counter change
//- Table read fetches pointer address, splits bytes
//- Flag register layout, eight named bits
//- Flag writes keep expiry and sleep bits
//- Sleep flag: sleep sets, kick clears
//- Carry out, no borrow, rotate through carry
//- Half carry from low nibble
//- Null flag follows zero result
//- Signed wrap: carry in differs carry out
//- Sign flag is wrap xor result top bit
//- Combined null per instruction, else unchanged
//- Flags never pushed on call or interrupt
module cscr_core_regs
#(
    parameter int ADDR_W = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dog_timeout,
    input wire logic [cscr_pkg::PMEM_W-1:0] pmem_rdata,
    output logic [cscr_pkg::PMEM_W-1:0] pmem_addr,
    output logic pmem_req,
    output logic [7:0] pc_low,
    output logic pc_jump,
    output logic fetch_bubble,
    output logic dog_kick,
    output logic sleep_req
);
    import cscr_pkg::*;

    cscr_state_type s_r;
    cscr_state_type s_nxt;
    cscr_alu_out_type alu_out;
    logic [7:0] addr8;
    logic [31:0] rd_val;
    logic hit;
    logic commit;
    logic cmd_commit;
    logic [3:0] cmd_op;

    assign addr8 = paddr[7:0];
    assign cmd_op = pwdata[3:0];
    // Write takes effect at the edge where pready is seen high
    assign commit = psel & penable & pwrite & s_r.pready & (s_r.seq == SEQ_IDLE);
    assign cmd_commit = commit & (addr8 == ADDR_CMD);

    cscr_alu cscr_alu_i
    (
        .op(cmd_op),
        .a(s_r.acc),
        .b(s_r.opd),
        .flags_in(s_r.flags),
        .result(alu_out)
    );

    // Read decode; reserved upper bits read zero
    always_comb
    begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (addr8 == ADDR_ACC)
        begin
            rd_val[7:0] = s_r.acc;
        end
        else if (addr8 == ADDR_PCL)
        begin
            rd_val[7:0] = s_r.prog_counter_low;
        end
        else if (addr8 == ADDR_LOOKUP_PTR_LOW)
        begin
            rd_val[7:0] = s_r.lookup_ptr_low;
        end
        else if (addr8 == ADDR_LOOKUP_PTR_HIGH)
        begin
            rd_val[7:0] = s_r.lookup_ptr_high;
        end
        else if (addr8 == ADDR_LOOKUP_RESULT_HIGH)
        begin
            rd_val[7:0] = s_r.lookup_result_high;
        end
        else if (addr8 == ADDR_FLAG)
        begin
            rd_val[7:0] = s_r.flags;
        end
        else if (addr8 == ADDR_OPD)
        begin
            rd_val[7:0] = s_r.opd;
        end
        else if (addr8 == ADDR_CMD)
        begin
            rd_val = 32'h0000_0000;
        end
        else
        begin
            hit = 1'b0;
        end
        if (ADDR_W > 8 && paddr[ADDR_W-1:0] != {{(ADDR_W-8){1'b0}}, addr8})
        begin
            hit = 1'b0;
            rd_val = 32'h0000_0000;
        end
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pc_jump = 1'b0;
        s_nxt.bubble = 1'b0;
        s_nxt.pmem_req = 1'b0;
        s_nxt.dog_kick = 1'b0;
        s_nxt.sleep_req = 1'b0;
        case (s_r.seq)
            SEQ_IDLE:
            begin
                if (psel && penable && !s_r.pready)
                begin
                    s_nxt.pready = 1'b1;
                    s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
                    s_nxt.pslverr = !hit;
                end
                else if (psel && penable && s_r.pready)
                begin
                    s_nxt.pready = 1'b0;
                    s_nxt.pslverr = 1'b0;
                end
            end
            SEQ_BUBBLE:
            begin
                s_nxt.seq = SEQ_IDLE;
            end
            SEQ_FETCH:
            begin
                s_nxt.seq = SEQ_LOAD;
            end
            default:
            begin
                s_nxt.lookup_result_high = pmem_rdata[15:8];
                if (s_r.tbl_dest)
                begin
                    s_nxt.opd = pmem_rdata[7:0];
                end
                else
                begin
                    s_nxt.acc = pmem_rdata[7:0];
                end
                s_nxt.seq = SEQ_IDLE;
            end
        endcase
        if (commit && hit)
        begin
            if (addr8 == ADDR_ACC)
            begin
                s_nxt.acc = pwdata[7:0];
            end
            else if (addr8 == ADDR_PCL)
            begin
                // Low byte only, page bits stay with the fetch unit
                s_nxt.prog_counter_low = pwdata[7:0];
                s_nxt.pc_jump = 1'b1;
                s_nxt.bubble = 1'b1;
                s_nxt.seq = SEQ_BUBBLE;
            end
            else if (addr8 == ADDR_LOOKUP_PTR_LOW)
            begin
                s_nxt.lookup_ptr_low = pwdata[7:0];
            end
            else if (addr8 == ADDR_LOOKUP_PTR_HIGH)
            begin
                s_nxt.lookup_ptr_high = pwdata[7:0];
            end
            else if (addr8 == ADDR_LOOKUP_RESULT_HIGH)
            begin
                s_nxt.lookup_result_high = pwdata[7:0];
            end
            else if (addr8 == ADDR_FLAG)
            begin
                s_nxt.flags = (pwdata[7:0] & ~FLAG_RO_MASK) | (s_r.flags & FLAG_RO_MASK);
            end
            else if (addr8 == ADDR_OPD)
            begin
                s_nxt.opd = pwdata[7:0];
            end
            else
            begin
                case (cmd_op)
                    CMD_MOV_TO_ACC: s_nxt.acc = s_r.opd;
                    CMD_MOV_FROM_ACC: s_nxt.opd = s_r.acc;
                    CMD_TABLE_READ:
                    begin
                        s_nxt.pmem_addr = {s_r.lookup_ptr_high, s_r.lookup_ptr_low};
                        s_nxt.pmem_req = 1'b1;
                        s_nxt.tbl_dest = pwdata[CMD_DEST_BIT];
                        s_nxt.seq = SEQ_FETCH;
                    end
                    CMD_DOG_KICK:
                    begin
                        s_nxt.flags[FLG_DOG_EXPIRY] = 1'b0;
                        s_nxt.flags[FLG_SLEEP_ENTRY] = 1'b0;
                        s_nxt.dog_kick = 1'b1;
                    end
                    CMD_SLEEP:
                    begin
                        s_nxt.flags[FLG_DOG_EXPIRY] = 1'b0;
                        s_nxt.flags[FLG_SLEEP_ENTRY] = 1'b1;
                        s_nxt.sleep_req = 1'b1;
                    end
                    default:
                    begin
                        s_nxt.acc = alu_out.res;
                        s_nxt.flags = alu_out.flags;
                    end
                endcase
            end
        end
        // Timeout wins over a clear in the same cycle
        if (dog_timeout)
        begin
            s_nxt.flags[FLG_DOG_EXPIRY] = 1'b1;
        end
    end

    // Flags live only here; nothing pushes them on call or interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign pmem_addr = s_r.pmem_addr;
    assign pmem_req = s_r.pmem_req;
    assign pc_low = s_r.prog_counter_low;
    assign pc_jump = s_r.pc_jump;
    assign fetch_bubble = s_r.bubble;
    assign dog_kick = s_r.dog_kick;
    assign sleep_req = s_r.sleep_req;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence add_cmd;
        cmd_commit && cmd_op == CMD_ADD;
    endsequence

    sequence pcl_write;
        commit && addr8 == ADDR_PCL;
    endsequence

    sequence jump_then_bubble;
        pc_jump && fetch_bubble ##1 !fetch_bubble && !pready;
    endsequence

    chk_acc_result: assert property (add_cmd
        |=> s_r.acc == 8'($past(s_r.acc) + $past(s_r.opd)))
        else $error("Working register missed the sum");
    chk_pcl_jump: assert property (pcl_write |=> pc_jump && pc_low == $past(pwdata[7:0]))
        else $error("Jump target not taken from write");
    chk_bubble_once: assert property (pcl_write |=> jump_then_bubble)
        else $error("Dummy cycle not exactly one");
    chk_table_split: assert property (pmem_req |=> ##1 s_r.lookup_result_high == $past(pmem_rdata[15:8]))
        else $error("Table high byte not captured");
    chk_table_addr: assert property (pmem_req |-> pmem_addr == {s_r.lookup_ptr_high, s_r.lookup_ptr_low})
        else $error("Table address not from pointers");
    chk_flag_ro: assert property (commit && addr8 == ADDR_FLAG && !dog_timeout
        |=> s_r.flags[5:4] == $past(s_r.flags[5:4]))
        else $error("Read-only flags changed by write");
    chk_dog_set: assert property (dog_timeout |=> s_r.flags[FLG_DOG_EXPIRY])
        else $error("Timeout did not set expiry flag");
    chk_sleep_set: assert property (cmd_commit && cmd_op == CMD_SLEEP && !dog_timeout
        |=> s_r.flags[FLG_SLEEP_ENTRY] && !s_r.flags[FLG_DOG_EXPIRY] && sleep_req)
        else $error("Sleep did not set flags");
    chk_carry_add: assert property (add_cmd
        |=> s_r.flags[FLG_ARITH_OUT]
        == (({1'b0, $past(s_r.acc)} + {1'b0, $past(s_r.opd)}) > 9'h0ff))
        else $error("Carry wrong after add");
    chk_zero_logic: assert property (cmd_commit && cmd_op == CMD_AND
        |=> s_r.flags[FLG_RESULT_NULL] == (s_r.acc == 8'h00)
        && $stable(s_r.flags[FLG_COMBINED_NULL]))
        else $error("Null flags wrong after logic op");
    chk_sign_xor: assert property (cmd_commit && cmd_op == CMD_SUB && !dog_timeout
        |=> s_r.flags[FLG_SIGN_RESULT] == (s_r.flags[FLG_SIGNED_WRAP] ^ s_r.acc[7]))
        else $error("Sign flag not wrap xor top bit");

endmodule : cscr_core_regs

//--- logic/cscr_pkg.sv
// Package for the CPU core register block: APB map, flag layout, commands, types.
// Assumes one clock domain and 32-bit APB data with byte addresses.
package cscr_pkg;

    // APB byte offsets, one word per register
    localparam logic [7:0] ADDR_ACC = 8'h00;
    localparam logic [7:0] ADDR_PCL = 8'h04;
    localparam logic [7:0] ADDR_LOOKUP_PTR_LOW = 8'h08;
    localparam logic [7:0] ADDR_LOOKUP_PTR_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_LOOKUP_RESULT_HIGH = 8'h10;
    localparam logic [7:0] ADDR_FLAG = 8'h14;
    localparam logic [7:0] ADDR_OPD = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1c;

    // Flag register bit positions
    localparam int FLG_ARITH_OUT = 0;
    localparam int FLG_HALF_NIBBLE = 1;
    localparam int FLG_RESULT_NULL = 2;
    localparam int FLG_SIGNED_WRAP = 3;
    localparam int FLG_SLEEP_ENTRY = 4;
    localparam int FLG_DOG_EXPIRY = 5;
    localparam int FLG_COMBINED_NULL = 6;
    localparam int FLG_SIGN_RESULT = 7;
    localparam logic [7:0] FLAG_RO_MASK = 8'h30;
    localparam logic [7:0] FLAG_RESET = 8'h00;

    // Command register fields
    localparam int CMD_DEST_BIT = 4;
    localparam logic [3:0] CMD_ADD = 4'h0;
    localparam logic [3:0] CMD_ADC = 4'h1;
    localparam logic [3:0] CMD_SUB = 4'h2;
    localparam logic [3:0] CMD_SBC = 4'h3;
    localparam logic [3:0] CMD_AND = 4'h4;
    localparam logic [3:0] CMD_OR = 4'h5;
    localparam logic [3:0] CMD_XOR = 4'h6;
    localparam logic [3:0] CMD_RLC = 4'h7;
    localparam logic [3:0] CMD_RRC = 4'h8;
    localparam logic [3:0] CMD_INC = 4'h9;
    localparam logic [3:0] CMD_DEC = 4'ha;
    localparam logic [3:0] CMD_MOV_TO_ACC = 4'hb;
    localparam logic [3:0] CMD_MOV_FROM_ACC = 4'hc;
    localparam logic [3:0] CMD_TABLE_READ = 4'hd;
    localparam logic [3:0] CMD_DOG_KICK = 4'he;
    localparam logic [3:0] CMD_SLEEP = 4'hf;

    localparam int PMEM_W = 16;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_BUBBLE, SEQ_FETCH, SEQ_LOAD} cscr_seq_type;

    typedef struct packed {
        logic [7:0] res;
        logic [7:0] flags;
    } cscr_alu_out_type;

    typedef struct packed {
        cscr_seq_type seq;
        logic [7:0] acc;
        logic [7:0] prog_counter_low;
        logic [7:0] lookup_ptr_low;
        logic [7:0] lookup_ptr_high;
        logic [7:0] lookup_result_high;
        logic [7:0] flags;
        logic [7:0] opd;
        logic tbl_dest;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [PMEM_W-1:0] pmem_addr;
        logic pmem_req;
        logic pc_jump;
        logic bubble;
        logic dog_kick;
        logic sleep_req;
    } cscr_state_type;

endpackage : cscr_pkg

//--- verif/cscr_core_regs_test.sv
// Self-checking bench for the CPU core register block, driven over APB.
// Assumes the block answers each access with pready and models program memory here.
module cscr_core_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import cscr_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dog_timeout = 1'b0;
    logic [15:0] pmem_rdata = 16'h0;
    logic [15:0] pmem_addr;
    logic pmem_req;
    logic [7:0] pc_low;
    logic pc_jump;
    logic fetch_bubble;
    logic dog_kick;
    logic sleep_req;
    int errors = 0;
    int n_compared = 0;
    int n_jump = 0;
    int n_pair = 0;
    int n_bubble = 0;
    int n_req = 0;
    int n_kick = 0;
    int n_sleep = 0;
    logic [31:0] rd;
    logic er;
    logic [7:0] flg;
    logic [15:0] mv;
    logic [3:0] ops [14] = '{CMD_ADD, CMD_ADD, CMD_ADC, CMD_SUB, CMD_SBC, CMD_SUB, CMD_SBC,
        CMD_AND, CMD_OR, CMD_XOR, CMD_RLC, CMD_RRC, CMD_INC, CMD_DEC};
    logic [7:0] av [14] = '{8'h7f, 8'hff, 8'h0f, 8'h05, 8'h05, 8'h80, 8'h00,
        8'hf0, 8'h00, 8'haa, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] bv [14] = '{8'h01, 8'h01, 8'h00, 8'h05, 8'h05, 8'h01, 8'h00,
        8'h0f, 8'h00, 8'haa, 8'h80, 8'h01, 8'hff, 8'h10};

    cscr_core_regs cscr_core_regs_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dog_timeout(dog_timeout), .pmem_rdata(pmem_rdata), .pmem_addr(pmem_addr),
        .pmem_req(pmem_req), .pc_low(pc_low), .pc_jump(pc_jump),
        .fetch_bubble(fetch_bubble), .dog_kick(dog_kick), .sleep_req(sleep_req)
    );

    always #25 pclk = ~pclk;

    function automatic logic [15:0] memw(input logic [15:0] a);
        return {a[7:0] ^ 8'h5a, a[15:8] ^ 8'ha5};
    endfunction : memw

    // Program memory answers the cycle after a request, otherwise keeps toggling
    always @(posedge pclk)
    begin
        pmem_rdata <= (pmem_req === 1'b1) ? memw(pmem_addr) : ~pmem_rdata;
        if (pc_jump === 1'b1) n_jump++;
        if (pc_jump === 1'b1 && fetch_bubble === 1'b1) n_pair++;
        if (fetch_bubble === 1'b1) n_bubble++;
        if (pmem_req === 1'b1) n_req++;
        if (dog_kick === 1'b1) n_kick++;
        if (sleep_req === 1'b1) n_sleep++;
    end

    // Reference result and flags of one ALU command
    function automatic logic [15:0] model(input logic [3:0] op, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] c7;
        logic [7:0] b2;
        logic ci;
        logic [7:0] r;
        logic [7:0] n;
        n = f;
        b2 = (op == CMD_SUB || op == CMD_SBC) ? ~b : b;
        ci = (op == CMD_ADD) ? 1'b0 : (op == CMD_SUB) ? 1'b1 : f[0];
        s = a + b2 + ci;
        h = a[3:0] + b2[3:0] + ci;
        c7 = a[6:0] + b2[6:0] + ci;
        case (op)
            CMD_AND: r = a & b;
            CMD_OR: r = a | b;
            CMD_XOR: r = a ^ b;
            CMD_INC: r = b + 8'h01;
            CMD_DEC: r = b - 8'h01;
            CMD_RLC: r = {b[6:0], f[0]};
            CMD_RRC: r = {f[0], b[7:1]};
            default: r = s[7:0];
        endcase
        if (op != CMD_RLC && op != CMD_RRC) n[2] = (r == 8'h00);
        if (op <= CMD_SBC)
        begin
            n[0] = s[8];
            n[1] = h[4];
            n[3] = c7[7] ^ s[8];
            n[7] = n[3] ^ r[7];
        end
        if (op == CMD_SUB) n[6] = n[2];
        if (op == CMD_SBC) n[6] = n[2] & f[2];
        if (op == CMD_RLC) n[0] = b[7];
        if (op == CMD_RRC) n[0] = b[0];
        return {r, n};
    endfunction : model

    task automatic test_done;
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            test_done();
        end
        // One idle edge between transfers; registered outputs settle
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk

    task automatic pulse_timeout;
        dog_timeout <= 1'b1;
        @(posedge pclk);
        dog_timeout <= 1'b0;
    endtask : pulse_timeout

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("flags after reset", ADDR_FLAG, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b1, ADDR_FLAG, 32'hff);
        rdchk("flags write", ADDR_FLAG, 32'hcf);
        flg = 8'hcf;
        for (int i = 0; i < 14; i++)
        begin
            apb(1'b1, ADDR_ACC, {24'h0, av[i]});
            apb(1'b1, ADDR_OPD, {24'h0, bv[i]});
            apb(1'b1, ADDR_CMD, {28'h0, ops[i]});
            mv = model(ops[i], av[i], bv[i], flg);
            flg = mv[7:0];
            rdchk("alu result", ADDR_ACC, {24'h0, mv[15:8]});
            rdchk("alu flags", ADDR_FLAG, {24'h0, flg});
        end
        apb(1'b1, ADDR_OPD, 32'h3c);
        apb(1'b1, ADDR_CMD, {28'h0, CMD_MOV_TO_ACC});
        apb(1'b1, ADDR_OPD, 32'h00);
        apb(1'b1, ADDR_CMD, {28'h0, CMD_MOV_FROM_ACC});
        rdchk("moved through acc", ADDR_OPD, 32'h3c);
        apb(1'b1, ADDR_PCL, 32'h5a);
        @(posedge pclk);
        chk("pc low", 32'h5a, {24'h0, pc_low});
        rdchk("pc low read", ADDR_PCL, 32'h5a);
        chk("jump pulses", 32'h1, n_jump);
        chk("dummy cycles", 32'h1, n_pair);
        chk("dummy cycle length", 32'h1, n_bubble);
        apb(1'b1, ADDR_LOOKUP_PTR_LOW, 32'h34);
        apb(1'b1, ADDR_LOOKUP_PTR_HIGH, 32'h12);
        apb(1'b1, ADDR_CMD, 32'h10 | CMD_TABLE_READ);
        chk("fetch address", 32'h1234, {16'h0, pmem_addr});
        mv = memw(16'h1234);
        rdchk("table high", ADDR_LOOKUP_RESULT_HIGH, {24'h0, mv[15:8]});
        rdchk("table low to opd", ADDR_OPD, {24'h0, mv[7:0]});
        apb(1'b1, ADDR_LOOKUP_PTR_LOW, 32'h35);
        apb(1'b1, ADDR_CMD, {28'h0, CMD_TABLE_READ});
        mv = memw(16'h1235);
        rdchk("stepped table high", ADDR_LOOKUP_RESULT_HIGH, {24'h0, mv[15:8]});
        rdchk("table low to acc", ADDR_ACC, {24'h0, mv[7:0]});
        chk("fetch requests", 32'h2, n_req);
        pulse_timeout();
        apb(1'b0, ADDR_FLAG, 32'h0);
        chk("expiry set", 32'h20, rd & 32'h30);
        apb(1'b1, ADDR_FLAG, 32'h0);
        apb(1'b0, ADDR_FLAG, 32'h0);
        chk("expiry kept on write", 32'h20, rd & 32'h30);
        apb(1'b1, ADDR_CMD, {28'h0, CMD_SLEEP});
        apb(1'b0, ADDR_FLAG, 32'h0);
        chk("sleep flags", 32'h10, rd & 32'h30);
        chk("sleep pulses", 32'h1, n_sleep);
        pulse_timeout();
        apb(1'b1, ADDR_CMD, {28'h0, CMD_DOG_KICK});
        apb(1'b0, ADDR_FLAG, 32'h0);
        chk("kick flags", 32'h0, rd & 32'h30);
        chk("kick pulses", 32'h1, n_kick);
        pulse_timeout();
        apb(1'b1, ADDR_CMD, {28'h0, CMD_SLEEP});
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_FLAG, 32'h0);
        chk("flags after second reset", 32'h0, rd & 32'h30);
        test_done();
    end
endmodule : cscr_core_regs_test
